// [rtl/sfr_pkg.sv]
package sfr_pkg;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_INDIRECT = 8'h00;
	localparam logic [7:0] ADDR_POINTER = 8'h01;
	localparam logic [7:0] ADDR_ACCUM = 8'h05;
	localparam logic [7:0] ADDR_PC_LOW = 8'h06;
	localparam logic [7:0] ADDR_TBL_PTR = 8'h07;
	localparam logic [7:0] ADDR_TBL_HIGH = 8'h08;
	localparam logic [7:0] ADDR_TBL_PAGE = 8'h09;
	localparam logic [7:0] ADDR_STATUS = 8'h0A;
	localparam logic [7:0] ADDR_INT_CTRL = 8'h0B;
	localparam logic [7:0] RAM_BASE = 8'h40;
	localparam int RAM_DEPTH = 64;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int ST_C = 0;
	localparam int ST_AC = 1;
	localparam int ST_Z = 2;
	localparam int ST_OV = 3;
	localparam int ST_PDF = 4;
	localparam int ST_TO = 5;
	localparam logic [5:0] ST_ARITH_MASK = 6'h0F;
	localparam int IC_GIE = 0;
	localparam int IC_TIMER_EN = 2;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [6:0] RST_PTR = 7'h00;
	localparam logic [2:0] TBL_PAGE_LAST = 3'h7;

	// ----------------------------------------------------------------
	// Core request carried from the execution core
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_READ = 3'b001,
		OP_WRITE = 3'b010,
		OP_SET_BIT = 3'b011,
		OP_CLR_BIT = 3'b100
	} op_e;

	typedef struct packed {
		op_e op;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [2:0] bit_sel;
	} mem_req_s;

	// Flag update from the ALU for one instruction
	typedef struct packed {
		logic upd_c;
		logic upd_ac;
		logic upd_z;
		logic upd_ov;
		logic c;
		logic ac;
		logic z;
		logic ov;
	} alu_flags_s;

	// System events
	typedef struct packed {
		logic wdt_clear;
		logic halt;
		logic wdt_timeout;
		logic int_entry;
		logic int_return;
	} sys_evt_s;

endpackage

// [rtl/core_special_function_regs.sv]
// Operation
// - Unused or reserved data addresses read back as zero.
// - Special registers start at address zero, below general RAM.
// - General RAM bytes are readable, writable and bit set/clear capable.
// - Address zero stores nothing; accesses go to pointer's target.
// - Indirect access to address zero reads zero, writes ignored.
// - Pointer keeps seven bits; bit seven always reads one.
// - Writing PC low jumps within page, keeps upper bits, one dummy cycle.
// - Table read puts high byte in table high register, low to operand.
// - Page option on, last page off: table address uses page register bits 2..0.
// - Page and last page options off: table address uses current PC upper bits.
// - Arithmetic flags writable; power-down and timeout flags not writable.
// - Carry set on add carry-out or subtract no-borrow; rotates too.
// - Aux carry set on low-nibble carry or no low-nibble borrow.
// - Zero flag set when result is zero.
// - Overflow set when carry into and out of top bit differ.
// - Power-down cleared on power-up or watchdog clear, set by halt.
// - Timeout cleared on power-up, watchdog clear or halt; set on timeout.
// - Status is never saved automatically on interrupt or call.
// - Global enable gates interrupts; cleared on entry, set on return.
// - Timer interrupt has its own independently controlled enable bit.
// - Table high register is read-only to software.
// - Every table read takes two instruction cycles.
`timescale 1ns/1ps

module core_special_function_regs #(
	parameter int PC_WIDTH = 11,
	parameter int RAM_WORDS = sfr_pkg::RAM_DEPTH
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Data memory request from the core
	input wire sfr_pkg::mem_req_s req_i,
	input wire sfr_pkg::alu_flags_s flags_i,
	input wire sfr_pkg::sys_evt_s evt_i,
	// Program counter tracking
	input wire logic pc_advance_i,
	// Table read request and program memory answer
	input wire logic tbl_read_i,
	input wire logic tbl_last_page_i,
	input wire logic tbl_page_enable_i,
	input wire logic [15:0] prog_data_i,
	// Data back to the core
	output logic [7:0] rdata_o,
	output logic [PC_WIDTH-1:0] pc_o,
	output logic dummy_cycle_o,
	output logic [PC_WIDTH-1:0] tbl_addr_o,
	output logic tbl_busy_o,
	output logic [7:0] tbl_low_o,
	output logic tbl_low_valid_o,
	output logic [7:0] status_o,
	output logic global_int_enable_o,
	output logic timer_int_enable_o
);

	// ----------------------------------------------------------------
	// Address resolution
	// ----------------------------------------------------------------
	logic [6:0] ptr_q;
	logic [7:0] eff_addr;
	logic indirect_self;
	logic is_write;
	logic [7:0] cur_val;
	logic [7:0] new_val;

	// Address zero is a window onto the pointer's target
	always_comb begin
		indirect_self = 1'b0;
		eff_addr = req_i.addr;
		if (req_i.addr == sfr_pkg::ADDR_INDIRECT) begin
			eff_addr = {1'b0, ptr_q};
			indirect_self = ({1'b0, ptr_q} == sfr_pkg::ADDR_INDIRECT);
		end
	end

	assign is_write = (req_i.op == sfr_pkg::OP_WRITE) ||
		(req_i.op == sfr_pkg::OP_SET_BIT) ||
		(req_i.op == sfr_pkg::OP_CLR_BIT);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [7:0] ram_q [RAM_WORDS];
	logic [7:0] acc_q;
	logic [PC_WIDTH-1:0] pc_q;
	logic [7:0] tbl_ptr_q;
	logic [7:0] tbl_high_q;
	logic [7:0] tbl_page_q;
	logic [5:0] status_q;
	logic [7:0] interrupt_control_q;
	logic ram_hit;
	logic [5:0] ram_idx;

	assign ram_hit = (eff_addr >= sfr_pkg::RAM_BASE) &&
		(eff_addr < sfr_pkg::RAM_BASE + 8'(RAM_WORDS));
	assign ram_idx = 6'(eff_addr - sfr_pkg::RAM_BASE);

	// Read mux; anything unmapped returns zero
	always_comb begin
		cur_val = sfr_pkg::RST_BYTE;
		if (indirect_self) begin
			cur_val = sfr_pkg::RST_BYTE;
		end else if (ram_hit) begin
			cur_val = ram_q[ram_idx];
		end else begin
			case (eff_addr)
				sfr_pkg::ADDR_POINTER: cur_val = {1'b1, ptr_q};
				sfr_pkg::ADDR_ACCUM: cur_val = acc_q;
				sfr_pkg::ADDR_PC_LOW: cur_val = pc_q[7:0];
				sfr_pkg::ADDR_TBL_PTR: cur_val = tbl_ptr_q;
				sfr_pkg::ADDR_TBL_HIGH: cur_val = tbl_high_q;
				sfr_pkg::ADDR_TBL_PAGE: cur_val = tbl_page_q;
				sfr_pkg::ADDR_STATUS: cur_val = {2'b00, status_q};
				sfr_pkg::ADDR_INT_CTRL: cur_val = interrupt_control_q;
				default: cur_val = sfr_pkg::RST_BYTE;
			endcase
		end
	end

	// Read-modify-write gives bit set and clear on every writable location
	always_comb begin
		case (req_i.op)
			sfr_pkg::OP_SET_BIT: new_val = cur_val | (8'h01 << req_i.bit_sel);
			sfr_pkg::OP_CLR_BIT: new_val = cur_val & ~(8'h01 << req_i.bit_sel);
			default: new_val = req_i.wdata;
		endcase
	end

	logic wr_ok;
	assign wr_ok = is_write && !indirect_self;

	// ----------------------------------------------------------------
	// General purpose RAM
	// ----------------------------------------------------------------
	// RAM holds no reset; software must initialise it
	always_ff @(posedge mclk_i) begin
		if (wr_ok && ram_hit) begin
			ram_q[ram_idx] <= new_val;
		end
	end

	// ----------------------------------------------------------------
	// Pointer and accumulator
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ptr_q <= sfr_pkg::RST_PTR;
			acc_q <= sfr_pkg::RST_BYTE;
		end else if (wr_ok) begin
			if (eff_addr == sfr_pkg::ADDR_POINTER) begin
				ptr_q <= new_val[6:0];
			end
			if (eff_addr == sfr_pkg::ADDR_ACCUM) begin
				acc_q <= new_val;
			end
		end
	end

	// ----------------------------------------------------------------
	// Program counter
	// ----------------------------------------------------------------
	// A low byte write is a jump in the page, followed by a dummy cycle
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_q <= '0;
			dummy_cycle_o <= 1'b0;
		end else begin
			dummy_cycle_o <= 1'b0;
			if (wr_ok && eff_addr == sfr_pkg::ADDR_PC_LOW) begin
				pc_q[7:0] <= new_val;
				dummy_cycle_o <= 1'b1;
			end else if (pc_advance_i && !dummy_cycle_o && !tbl_busy_o) begin
				pc_q <= pc_q + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Table read
	// ----------------------------------------------------------------
	logic [PC_WIDTH-1:0] tbl_addr_d;

	// Upper address bits come from the last page, the page register or the live PC
	always_comb begin
		tbl_addr_d = pc_q;
		tbl_addr_d[7:0] = tbl_ptr_q;
		if (tbl_last_page_i) begin
			tbl_addr_d[PC_WIDTH-1:8] = '1;
		end else if (tbl_page_enable_i) begin
			tbl_addr_d[PC_WIDTH-1:8] =
				(PC_WIDTH-8)'(tbl_page_q[2:0]);
		end else begin
			tbl_addr_d[PC_WIDTH-1:8] = pc_q[PC_WIDTH-1:8];
		end
	end

	// Two cycles: issue the address, then take the program data
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tbl_busy_o <= 1'b0;
			tbl_addr_o <= '0;
			tbl_high_q <= sfr_pkg::RST_BYTE;
			tbl_low_o <= sfr_pkg::RST_BYTE;
			tbl_low_valid_o <= 1'b0;
		end else begin
			tbl_low_valid_o <= 1'b0;
			if (tbl_busy_o) begin
				tbl_busy_o <= 1'b0;
				tbl_high_q <= prog_data_i[15:8];
				tbl_low_o <= prog_data_i[7:0];
				tbl_low_valid_o <= 1'b1;
			end else if (tbl_read_i) begin
				tbl_busy_o <= 1'b1;
				tbl_addr_o <= tbl_addr_d;
			end
		end
	end
	// Software writes to the table high address fall through

	// ----------------------------------------------------------------
	// Table pointer and page registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tbl_ptr_q <= sfr_pkg::RST_BYTE;
			tbl_page_q <= sfr_pkg::RST_BYTE;
		end else if (wr_ok) begin
			if (eff_addr == sfr_pkg::ADDR_TBL_PTR) begin
				tbl_ptr_q <= new_val;
			end
			if (eff_addr == sfr_pkg::ADDR_TBL_PAGE) begin
				tbl_page_q <= new_val;
			end
		end
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	localparam int ST_ARITH_W = 4;
	logic [5:0] status_d;

	// ALU results win over a same-cycle software write of the flags
	always_comb begin
		status_d = status_q;
		if (wr_ok && eff_addr == sfr_pkg::ADDR_STATUS) begin
			status_d[ST_ARITH_W-1:0] = new_val[3:0];
		end
		if (flags_i.upd_c) status_d[sfr_pkg::ST_C] = flags_i.c;
		if (flags_i.upd_ac) status_d[sfr_pkg::ST_AC] = flags_i.ac;
		if (flags_i.upd_z) status_d[sfr_pkg::ST_Z] = flags_i.z;
		if (flags_i.upd_ov) status_d[sfr_pkg::ST_OV] = flags_i.ov;
		// Only system events touch power-down and timeout
		if (evt_i.wdt_clear) begin
			status_d[sfr_pkg::ST_PDF] = 1'b0;
			status_d[sfr_pkg::ST_TO] = 1'b0;
		end
		if (evt_i.halt) begin
			status_d[sfr_pkg::ST_PDF] = 1'b1;
			status_d[sfr_pkg::ST_TO] = 1'b0;
		end
		if (evt_i.wdt_timeout) begin
			status_d[sfr_pkg::ST_TO] = 1'b1;
		end
	end

	// Status never shadows on interrupt or call; software saves it
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status_q <= '0;
		end else begin
			status_q <= status_d;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt control
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			interrupt_control_q <= sfr_pkg::RST_BYTE;
		end else begin
			if (wr_ok && eff_addr == sfr_pkg::ADDR_INT_CTRL) begin
				interrupt_control_q <= new_val;
			end
			if (evt_i.int_entry) begin
				interrupt_control_q[sfr_pkg::IC_GIE] <= 1'b0;
			end else if (evt_i.int_return) begin
				interrupt_control_q[sfr_pkg::IC_GIE] <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= sfr_pkg::RST_BYTE;
			pc_o <= '0;
			status_o <= sfr_pkg::RST_BYTE;
			global_int_enable_o <= 1'b0;
			timer_int_enable_o <= 1'b0;
		end else begin
			rdata_o <= cur_val;
			pc_o <= pc_q;
			status_o <= {2'b00, status_d};
			global_int_enable_o <= interrupt_control_q[sfr_pkg::IC_GIE];
			timer_int_enable_o <= interrupt_control_q[sfr_pkg::IC_TIMER_EN];
		end
	end

endmodule

// [verification/prog_mem_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Program memory side of the execution core
// ------------------------------------------------------------
module prog_mem_model (
	// Clock
	input wire logic mclk_i,
	// Table fetch from the block
	input wire logic busy_i,
	input wire logic [10:0] addr_i,
	// Program word back
	output logic [15:0] data_o
);
	logic [15:0] junk_q = 16'h5A5A;

	// Changing filler so a stale word can never pass for a good one
	always_ff @(posedge mclk_i) begin
		junk_q <= ~junk_q + 16'h0001;
	end

	// Word encodes its own address; low byte scrambled for checking
	assign data_o = busy_i ? {addr_i[7:0], addr_i[7:0] ^ 8'hC3} : junk_q;
endmodule

// [verification/core_sfr_monitor.sv]
`timescale 1ns/1ps
module core_sfr_monitor #(
	parameter int PC_WIDTH = 11
) (
	// Clock, reset and requests
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire sfr_pkg::mem_req_s req_i,
	input wire sfr_pkg::sys_evt_s evt_i,
	input wire logic tbl_read_i,
	input wire logic [15:0] prog_data_i,
	// Outputs under watch
	input wire logic [7:0] rdata_o,
	input wire logic [PC_WIDTH-1:0] pc_o,
	input wire logic dummy_cycle_o,
	input wire logic tbl_busy_o,
	input wire logic [7:0] tbl_low_o,
	input wire logic tbl_low_valid_o,
	input wire logic [7:0] status_o,
	input wire logic global_int_enable_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_pc_jump;
		req_i.op == sfr_pkg::OP_WRITE && req_i.addr == sfr_pkg::ADDR_PC_LOW
		|=> dummy_cycle_o ##1 pc_o[7:0] == $past(req_i.wdata, 2)
		&& pc_o[PC_WIDTH-1:8] == $past(pc_o[PC_WIDTH-1:8]);
	endproperty
	a_pc_jump: assert property (p_pc_jump)
		else $error("pc low write wrong");
	property p_tbl_span;
		tbl_read_i && !tbl_busy_o |=> tbl_busy_o ##1 !tbl_busy_o;
	endproperty
	a_tbl_span: assert property (p_tbl_span)
		else $error("table read not two cycles");
	property p_tbl_low;
		tbl_busy_o |=> tbl_low_valid_o && tbl_low_o == $past(prog_data_i[7:0]);
	endproperty
	a_tbl_low: assert property (p_tbl_low)
		else $error("table low byte wrong");
	property p_ptr_msb;
		req_i.op == sfr_pkg::OP_READ && req_i.addr == sfr_pkg::ADDR_POINTER
		|=> rdata_o[7];
	endproperty
	a_ptr_msb: assert property (p_ptr_msb)
		else $error("pointer top bit low");
	property p_reserved;
		req_i.op == sfr_pkg::OP_READ && req_i.addr > sfr_pkg::ADDR_INT_CTRL
		&& req_i.addr < sfr_pkg::RAM_BASE |=> rdata_o == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved read not zero");
	property p_halt;
		evt_i.halt && !evt_i.wdt_timeout |=> status_o[5:4] == 2'h1;
	endproperty
	a_halt: assert property (p_halt)
		else $error("halt flags wrong");
	property p_timeout;
		evt_i.wdt_timeout |=> status_o[5];
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("timeout flag not set");
	property p_status_wr;
		req_i.op == sfr_pkg::OP_WRITE && req_i.addr == sfr_pkg::ADDR_STATUS
		&& evt_i == 5'h00 |=> status_o[5:4] == $past(status_o[5:4]);
	endproperty
	a_status_wr: assert property (p_status_wr)
		else $error("status write moved system flags");
	property p_int_entry;
		evt_i.int_entry |=> ##1 !global_int_enable_o;
	endproperty
	a_int_entry: assert property (p_int_entry)
		else $error("global enable kept on entry");
endmodule

bind core_special_function_regs core_sfr_monitor #(.PC_WIDTH(PC_WIDTH)) u_mon (
	.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req_i), .evt_i(evt_i),
	.tbl_read_i(tbl_read_i), .prog_data_i(prog_data_i), .rdata_o(rdata_o),
	.pc_o(pc_o), .dummy_cycle_o(dummy_cycle_o), .tbl_busy_o(tbl_busy_o),
	.tbl_low_o(tbl_low_o), .tbl_low_valid_o(tbl_low_valid_o),
	.status_o(status_o), .global_int_enable_o(global_int_enable_o));

// [verification/test_core_special_function_regs.sv]
`timescale 1ns/1ps
module test_core_special_function_regs;
	logic mclk_i, rst_n_i, pc_advance_i, tbl_read_i, dummy_cycle_o;
	logic tbl_last_page_i, tbl_page_enable_i, tbl_busy_o, tbl_low_valid_o;
	logic global_int_enable_o, timer_int_enable_o;
	sfr_pkg::mem_req_s req_i;
	sfr_pkg::alu_flags_s flags_i;
	sfr_pkg::sys_evt_s evt_i;
	logic [15:0] prog_data_i;
	logic [7:0] rdata_o, tbl_low_o, status_o, rd;
	logic [10:0] pc_o, tbl_addr_o;
	int errors, checked;

	core_special_function_regs i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.req_i(req_i), .flags_i(flags_i), .evt_i(evt_i),
		.pc_advance_i(pc_advance_i), .tbl_read_i(tbl_read_i),
		.tbl_last_page_i(tbl_last_page_i), .tbl_page_enable_i(tbl_page_enable_i),
		.prog_data_i(prog_data_i), .rdata_o(rdata_o), .pc_o(pc_o),
		.dummy_cycle_o(dummy_cycle_o), .tbl_addr_o(tbl_addr_o),
		.tbl_busy_o(tbl_busy_o), .tbl_low_o(tbl_low_o),
		.tbl_low_valid_o(tbl_low_valid_o), .status_o(status_o),
		.global_int_enable_o(global_int_enable_o),
		.timer_int_enable_o(timer_int_enable_o));
	prog_mem_model i_mem (.mclk_i(mclk_i), .busy_i(tbl_busy_o),
		.addr_i(tbl_addr_o), .data_o(prog_data_i));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Request is held, so the next call replaces it at the next edge
	task automatic acc(input sfr_pkg::op_e op, input logic [7:0] a,
		input logic [7:0] d);
		req_i = '{op, a, d, d[2:0]};
		@(negedge mclk_i);
		rd = rdata_o;
	endtask
	task automatic ev(input logic [4:0] e);
		evt_i = e;
		@(negedge mclk_i);
		evt_i = 5'h00;
		@(negedge mclk_i);
	endtask
	task automatic evs(input logic [4:0] e, input logic [7:0] exp);
		ev(e);
		acc(sfr_pkg::OP_READ, sfr_pkg::ADDR_STATUS, 8'h00);
		chk(16'(rd), 16'(exp));
	endtask
	task automatic done(input string n);
		req_i.op = sfr_pkg::OP_NONE;
		@(negedge mclk_i);
		$display("test %s finished", n);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_map;
		acc(sfr_pkg::OP_READ, 8'h20, 8'h00);
		chk(16'(rd), 16'h0000);
		acc(sfr_pkg::OP_READ, sfr_pkg::ADDR_POINTER, 8'h00);
		chk(16'(rd), 16'h0080);
		acc(sfr_pkg::OP_WRITE, sfr_pkg::ADDR_TBL_HIGH, 8'hFF);
		acc(sfr_pkg::OP_READ, sfr_pkg::ADDR_TBL_HIGH, 8'h00);
		chk(16'(rd), 16'h0000);
		acc(sfr_pkg::OP_WRITE, 8'h7F, 8'h81);
		acc(sfr_pkg::OP_SET_BIT, 8'h7F, 8'h03);
		acc(sfr_pkg::OP_CLR_BIT, 8'h7F, 8'h00);
		acc(sfr_pkg::OP_READ, 8'h7F, 8'h00);
		chk(16'(rd), 16'h0088);
		done("map");
	endtask
	task automatic t_indirect;
		acc(sfr_pkg::OP_WRITE, sfr_pkg::ADDR_POINTER, 8'h45);
		acc(sfr_pkg::OP_WRITE, sfr_pkg::ADDR_INDIRECT, 8'h5A);
		acc(sfr_pkg::OP_READ, 8'h45, 8'h00);
		chk(16'(rd), 16'h005A);
		acc(sfr_pkg::OP_READ, sfr_pkg::ADDR_INDIRECT, 8'h00);
		chk(16'(rd), 16'h005A);
		acc(sfr_pkg::OP_READ, sfr_pkg::ADDR_POINTER, 8'h00);
		chk(16'(rd), 16'h00C5);
		acc(sfr_pkg::OP_WRITE, sfr_pkg::ADDR_POINTER, 8'h00);
		acc(sfr_pkg::OP_WRITE, sfr_pkg::ADDR_INDIRECT, 8'h77);
		acc(sfr_pkg::OP_READ, sfr_pkg::ADDR_INDIRECT, 8'h00);
		chk(16'(rd), 16'h0000);
		done("indirect");
	endtask
	// Upper address bits come from last page, page register or PC
	task automatic tbl(input logic last, input logic pen, input logic [10:0] a);
		tbl_last_page_i = last;
		tbl_page_enable_i = pen;
		tbl_read_i = 1'b1;
		@(negedge mclk_i);
		tbl_read_i = 1'b0;
		chk(16'(tbl_busy_o), 16'h0001);
		chk(16'(tbl_addr_o), 16'(a));
		@(negedge mclk_i);
		chk(16'(tbl_low_valid_o), 16'h0001);
		chk(16'(tbl_low_o), 16'(a[7:0] ^ 8'hC3));
		acc(sfr_pkg::OP_READ, sfr_pkg::ADDR_TBL_HIGH, 8'h00);
		chk(16'(rd), 16'(a[7:0]));
	endtask
	task automatic t_table;
		acc(sfr_pkg::OP_WRITE, sfr_pkg::ADDR_TBL_PTR, 8'h06);
		acc(sfr_pkg::OP_WRITE, sfr_pkg::ADDR_TBL_PAGE, 8'hFD);
		tbl(1'b1, 1'b0, 11'h706);
		tbl(1'b0, 1'b1, 11'h506);
		tbl(1'b0, 1'b0, 11'h006);
		done("table");
	endtask
	task automatic t_status;
		acc(sfr_pkg::OP_WRITE, sfr_pkg::ADDR_STATUS, 8'hFF);
		acc(sfr_pkg::OP_READ, sfr_pkg::ADDR_STATUS, 8'h00);
		chk(16'(rd), 16'h000F);
		evs(5'h08, 8'h1F);
		evs(5'h04, 8'h3F);
		evs(5'h08, 8'h1F);
		evs(5'h10, 8'h0F);
		flags_i = 8'hF5;
		@(negedge mclk_i);
		flags_i = 8'h00;
		acc(sfr_pkg::OP_READ, sfr_pkg::ADDR_STATUS, 8'h00);
		chk(16'(rd), 16'h000A);
		done("status");
	endtask
	task automatic t_ctrl;
		acc(sfr_pkg::OP_WRITE, sfr_pkg::ADDR_PC_LOW, 8'h33);
		chk(16'(dummy_cycle_o), 16'h0001);
		// Outputs follow the registers one clock later
		@(negedge mclk_i);
		chk(16'(pc_o), 16'h0033);
		acc(sfr_pkg::OP_WRITE, sfr_pkg::ADDR_INT_CTRL, 8'h05);
		@(negedge mclk_i);
		chk(16'({global_int_enable_o, timer_int_enable_o}), 16'h3);
		acc(sfr_pkg::OP_CLR_BIT, sfr_pkg::ADDR_INT_CTRL, 8'h00);
		@(negedge mclk_i);
		chk(16'({global_int_enable_o, timer_int_enable_o}), 16'h1);
		req_i.op = sfr_pkg::OP_NONE;
		ev(5'h01);
		chk(16'(global_int_enable_o), 16'h0001);
		ev(5'h02);
		chk(16'(global_int_enable_o), 16'h0000);
		done("control");
	endtask

	// Clock, hang limit and main sequence
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	initial begin
		repeat (5000) @(posedge mclk_i);
		errors++;
		finish_test;
	end
	initial begin
		errors = 0;
		checked = 0;
		rst_n_i = 1'b0;
		req_i = '0;
		flags_i = '0;
		evt_i = '0;
		{pc_advance_i, tbl_read_i, tbl_last_page_i, tbl_page_enable_i} = 4'h0;
		repeat (16) @(negedge mclk_i);
		rst_n_i = 1'b1;
		t_map;
		t_indirect;
		t_table;
		t_status;
		t_ctrl;
		finish_test;
	end
endmodule
